// ==== sim/indexed_exec_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module indexed_exec_asserts (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_extended_set_enable_cfg,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic [11:0] i_frame_pointer_reg,
	input wire logic [7:0] i_read_data,
	input wire logic o_claimed,
	input wire logic o_flags_write,
	input wire indexed_exec_pkg::mem_write_t o_mem_write
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	wire logic take = i_instr_valid && i_extended_set_enable_cfg && i_instr[7:0] <= 8'h5f;
	wire logic set_hit = take && i_instr[15:12] == 4'h8 && !i_instr[8];
	wire logic fill_hit = take && i_instr[15:8] == 8'h68;
	chk_claim_match: assert property (o_claimed == (set_hit || fill_hit))
		else $error("claim");
	chk_bit_set: assert property (set_hit |=> o_mem_write.data ==
		($past(i_read_data) | 8'h01 << $past(i_instr[11:9]))) else $error("bit");
	chk_fill_ones: assert property (fill_hit |=> o_mem_write.data == 8'hff) else $error("fill");
	chk_write_addr: assert property (o_claimed |=> o_mem_write.valid && o_mem_write.addr ==
		$past(i_frame_pointer_reg) + $past(i_instr[7:0])) else $error("addr");
	chk_one_cycle: assert property (!o_claimed |=> !o_mem_write.valid) else $error("idle");
	chk_flags_kept: assert property (!o_flags_write) else $error("flags");
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_clock, i_rstn, i_extended_set_enable_cfg, i_instr_valid, o_claimed, o_flags_write;
	logic [15:0] i_instr;
	logic [11:0] i_frame_pointer_reg;
	logic [7:0] i_read_data;
	indexed_exec_pkg::mem_write_t o_mem_write;
	int fails, tests_run;
	logic [45:0] r [7];
	indexed_bit_set_and_fill indexed_bit_set_and_fill_i (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_extended_set_enable_cfg(i_extended_set_enable_cfg),
		.i_instr_valid(i_instr_valid),
		.i_instr(i_instr),
		.i_frame_pointer_reg(i_frame_pointer_reg),
		.i_read_data(i_read_data),
		.o_claimed(o_claimed),
		.o_flags_write(o_flags_write),
		.o_mem_write(o_mem_write)
	);
	task automatic chk(input logic c);
		tests_run++;
		if (c !== 1'b1) begin
			fails++;
			$display("wrong value at %0t: check %0d", $time, tests_run);
		end
	endtask
	task automatic close_out;
		if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		i_clock = 0;
		forever #2.5 i_clock = ~i_clock;
	end
	initial begin
		#2000;
		fails++;
		close_out();
	end
	initial begin
		// Row: cfg, instr, fp, read byte, claim, written byte
		r = '{{1'h1, 16'h8e0a, 12'ha00, 8'h55, 1'h1, 8'hd5},
			{1'h1, 16'h682c, 12'ha00, 8'h00, 1'h1, 8'hff},
			{1'h1, 16'h805f, 12'h100, 8'h80, 1'h1, 8'h81},
			{1'h1, 16'h8060, 12'h100, 8'h00, 1'h0, 8'h00},
			{1'h1, 16'h8f00, 12'h100, 8'h00, 1'h0, 8'h00},
			{1'h0, 16'h682c, 12'ha00, 8'h00, 1'h0, 8'h00},
			{1'h1, 16'h6860, 12'h100, 8'h00, 1'h0, 8'h00}};
		{i_rstn, i_extended_set_enable_cfg, i_instr_valid} = '0;
		{i_instr, i_frame_pointer_reg, i_read_data} = '0;
		repeat (10) @(posedge i_clock);
		#1 i_rstn = 1'h1;
		// Rows go back to back so a stale write would spill into the next check
		for (int i = 0; i < 8; i++) begin
			@(posedge i_clock);
			#1;
			if (i > 0) chk(o_mem_write.valid === r[i-1][8] && (!r[i-1][8] ||
				o_mem_write.data === r[i-1][7:0] && o_mem_write.mask === 8'hff &&
				o_mem_write.addr === r[i-1][28:17] + r[i-1][36:29]));
			if (i < 7) begin
				{i_extended_set_enable_cfg, i_instr} = r[i][45:29];
				{i_frame_pointer_reg, i_read_data} = r[i][28:9];
			end
			i_instr_valid = i < 7;
			#1 if (i < 7) chk(o_claimed === r[i][8]);
		end
		// Valid low: a matching word in view must not be taken
		@(posedge i_clock);
		#1 {i_extended_set_enable_cfg, i_instr, i_read_data} = {1'h1, 16'h8e0a, 8'h55};
		#1 chk(o_claimed === 1'h0);
		@(posedge i_clock);
		#1 chk(o_mem_write.valid === 1'h0);
		// Mid-run reset with an op in view: the write port stays clear
		{i_rstn, i_instr_valid} = 2'h1;
		@(posedge i_clock);
		#1 chk(o_mem_write === '0 && o_flags_write === 1'h0);
		{i_rstn, i_frame_pointer_reg} = {1'h1, 12'ha00};
		#1 chk(o_claimed === 1'h1);
		@(posedge i_clock);
		#1 chk(o_mem_write.valid === 1'h1 && o_mem_write.data === 8'hd5 &&
			o_mem_write.addr === 12'ha0a);
		close_out();
	end
endmodule
bind indexed_bit_set_and_fill indexed_exec_asserts indexed_exec_asserts_i (
	.i_clock(i_clock),
	.i_rstn(i_rstn),
	.i_extended_set_enable_cfg(i_extended_set_enable_cfg),
	.i_instr_valid(i_instr_valid),
	.i_instr(i_instr),
	.i_frame_pointer_reg(i_frame_pointer_reg),
	.i_read_data(i_read_data),
	.o_claimed(o_claimed),
	.o_flags_write(o_flags_write),
	.o_mem_write(o_mem_write)
);
`default_nettype wire

// ==== src/indexed_bit_set_and_fill.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Bit set op sets bit bbb of byte at frame pointer plus offset.
// - Offsets 0..95 and bit selects 0..7 are accepted in indexed form.
// - Fill op writes all ones to byte at frame pointer plus offset.
// - With enable config bit clear, indexed ops and mode are off.
// - When enabled, operand addresses up to 5Fh are frame-pointer offsets.
module indexed_bit_set_and_fill #(
	parameter int ADDR_W = indexed_exec_pkg::ADDR_W
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_extended_set_enable_cfg,
	input wire logic i_instr_valid,
	input wire logic [indexed_exec_pkg::OPC_W-1:0] i_instr,
	input wire logic [ADDR_W-1:0] i_frame_pointer_reg,
	input wire logic [7:0] i_read_data,
	output logic o_claimed,
	output logic o_flags_write,
	output var indexed_exec_pkg::mem_write_t o_mem_write
);

	// ----------------------------------------
	// Field helpers
	// ----------------------------------------
	// One field map for decode and execute
	function automatic logic [3:0] top_nibble(
		input logic [indexed_exec_pkg::OPC_W-1:0] word
	);
		return word[indexed_exec_pkg::top_hi:indexed_exec_pkg::top_lo];
	endfunction

	function automatic logic [3:0] second_nibble(
		input logic [indexed_exec_pkg::OPC_W-1:0] word
	);
		return word[indexed_exec_pkg::sec_hi:indexed_exec_pkg::sec_lo];
	endfunction

	function automatic logic [7:0] offset_field(
		input logic [indexed_exec_pkg::OPC_W-1:0] word
	);
		return word[indexed_exec_pkg::lit_hi:indexed_exec_pkg::lit_lo];
	endfunction

	function automatic logic [2:0] bit_select_field(
		input logic [indexed_exec_pkg::OPC_W-1:0] word
	);
		return word[indexed_exec_pkg::bsel_hi:indexed_exec_pkg::bsel_lo];
	endfunction

	// Offsets past the limit stay with the legacy access-bank decode
	function automatic logic offset_in_range(
		input logic [7:0] offset
	);
		return offset <= indexed_exec_pkg::lit_max;
	endfunction

	function automatic logic is_bit_set_code(
		input logic [indexed_exec_pkg::OPC_W-1:0] word
	);
		return top_nibble(word) == indexed_exec_pkg::bit_set_top
			&& !word[indexed_exec_pkg::sec_low_bit];
	endfunction

	function automatic logic is_fill_code(
		input logic [indexed_exec_pkg::OPC_W-1:0] word
	);
		return top_nibble(word) == indexed_exec_pkg::fill_top
			&& second_nibble(word) == indexed_exec_pkg::fill_second;
	endfunction

	function automatic logic [7:0] bit_mask_of(
		input logic [2:0] sel
	);
		return 8'h01 << sel;
	endfunction

	function automatic logic [7:0] merged_byte(
		input logic [7:0] read_byte,
		input logic [2:0] sel
	);
		return read_byte | bit_mask_of(sel);
	endfunction

	// Wraps at the top of data space, as the pointer adder does
	function automatic logic [ADDR_W-1:0] frame_address(
		input logic [ADDR_W-1:0] pointer,
		input logic [7:0] offset
	);
		return pointer + ADDR_W'(offset);
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	indexed_exec_pkg::indexed_op_t op;
	logic [7:0] literal;
	logic [2:0] bit_sel;
	logic lit_ok;
	logic mode_on;
	logic set_code;
	logic fill_code;

	assign literal = offset_field(i_instr);
	assign bit_sel = bit_select_field(i_instr);
	assign lit_ok = offset_in_range(literal);
	// Disabled: opcodes fall back to the legacy decoder untouched
	assign mode_on = i_instr_valid && i_extended_set_enable_cfg;
	assign set_code = is_bit_set_code(i_instr);
	assign fill_code = is_fill_code(i_instr);

	always_comb begin
		op = indexed_exec_pkg::op_none;
		if (mode_on && lit_ok) begin
			if (set_code) begin
				op = indexed_exec_pkg::op_bit_set;
			end else if (fill_code) begin
				op = indexed_exec_pkg::op_fill;
			end
		end
	end

	// ----------------------------------------
	// Claim
	// ----------------------------------------
	// Combinational so the core can steer its own decode this cycle
	assign o_claimed = op != indexed_exec_pkg::op_none;

	// ----------------------------------------
	// Status
	// ----------------------------------------
	// Neither op touches arithmetic status
	assign o_flags_write = 1'h0;

	// ----------------------------------------
	// Next address
	// ----------------------------------------
	logic next_valid;
	logic [ADDR_W-1:0] next_addr;

	// One word in, one write out, no stall path
	assign next_valid = o_claimed;
	assign next_addr = frame_address(i_frame_pointer_reg, literal);

	// ----------------------------------------
	// Next data
	// ----------------------------------------
	logic [7:0] next_data;

	always_comb begin
		next_data = '0;
		unique case (op)
			indexed_exec_pkg::op_bit_set: begin
				// Read-modify-write keeps the other seven bits
				next_data = merged_byte(i_read_data, bit_sel);
			end
			indexed_exec_pkg::op_fill: begin
				next_data = indexed_exec_pkg::fill_value;
			end
			indexed_exec_pkg::op_none: begin
				next_data = '0;
			end
		endcase
	end

	// ----------------------------------------
	// Write port registers
	// ----------------------------------------
	logic write_valid;
	logic [ADDR_W-1:0] write_addr;
	logic [7:0] write_data;
	logic [7:0] write_mask;

	// Valid is a one-cycle pulse per claimed word
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			write_valid <= 1'h0;
		end else begin
			write_valid <= next_valid;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			write_addr <= '0;
		end else begin
			write_addr <= next_addr;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			write_data <= '0;
		end else begin
			write_data <= next_data;
		end
	end

	// Whole byte lanes: bit set already merged the read byte
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			write_mask <= '0;
		end else begin
			write_mask <= '1;
		end
	end

	// ----------------------------------------
	// Write port
	// ----------------------------------------
	always_comb begin
		o_mem_write = '0;
		o_mem_write.valid = write_valid;
		o_mem_write.addr = write_addr;
		o_mem_write.data = write_data;
		o_mem_write.mask = write_mask;
	end

endmodule
`default_nettype wire

// ==== src/indexed_exec_pkg.sv ====
package indexed_exec_pkg;

	// ----------------------------------------
	// Encoding fields
	// ----------------------------------------
	localparam int OPC_W = 16;
	localparam int ADDR_W = 12;
	localparam logic [3:0] bit_set_top = 4'h8;
	localparam logic [3:0] fill_top = 4'h6;
	localparam logic [3:0] fill_second = 4'h8;
	localparam int top_hi = 15;
	localparam int top_lo = 12;
	localparam int sec_hi = 11;
	localparam int sec_lo = 8;
	localparam int bsel_hi = 11;
	localparam int bsel_lo = 9;
	localparam int sec_low_bit = 8;
	localparam int lit_hi = 7;
	localparam int lit_lo = 0;
	localparam logic [7:0] lit_max = 8'h5f;
	localparam logic [7:0] fill_value = 8'hff;
	localparam logic [ADDR_W-1:0] fp_reset = 12'h000;

	typedef enum logic [1:0] {
		op_none,
		op_bit_set,
		op_fill
	} indexed_op_t;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
		logic [7:0] mask;
	} mem_write_t;

endpackage
